// ===== verilog/bps_cfg.svh
// Constants for the bipolar stepper phase sequencer.
`ifndef BPS_CFG_SVH
`define BPS_CFG_SVH

// ----------------------------------------------------------------------
// Position stepping
// ----------------------------------------------------------------------
`define BPS_POS_HOME 3'h0
`define BPS_STEP_HALF 3'h1
`define BPS_STEP_FULL 3'h2

// ----------------------------------------------------------------------
// Coil patterns per position, bit order a_pos a_neg b_pos b_neg
// ----------------------------------------------------------------------
`define BPS_PAT_P0 4'hA
`define BPS_PAT_P1 4'h2
`define BPS_PAT_P2 4'h6
`define BPS_PAT_P3 4'h4
`define BPS_PAT_P4 4'h5
`define BPS_PAT_P5 4'h1
`define BPS_PAT_P6 4'h9
`define BPS_PAT_P7 4'h8
`define BPS_PAT_OFF 4'h0

// ----------------------------------------------------------------------
// Coil drive enables per position, bit order coil_a coil_b
// ----------------------------------------------------------------------
`define BPS_EN_BOTH 2'h3
`define BPS_EN_A 2'h2
`define BPS_EN_B 2'h1
`define BPS_EN_NONE 2'h0

`endif

// ===== verilog/bps_pkg.sv
// Types shared by the bipolar stepper phase sequencer.
package bps_pkg;

  // ----------------------------------------------------------------------
  // Rotor position within the eight-entry half-step cycle
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    BPS_P0 = 3'h0,
    BPS_P1 = 3'h1,
    BPS_P2 = 3'h2,
    BPS_P3 = 3'h3,
    BPS_P4 = 3'h4,
    BPS_P5 = 3'h5,
    BPS_P6 = 3'h6,
    BPS_P7 = 3'h7
  } bps_pos_t;

  // ----------------------------------------------------------------------
  // Coil output levels and drive enables
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic a_pos;
    logic a_neg;
    logic b_pos;
    logic b_neg;
  } bps_coil_t;

  typedef struct packed {
    logic coil_a;
    logic coil_b;
  } bps_drive_t;

endpackage

// ===== verilog/bps_rise_detect.sv
// Rising-edge detector for the step clock input.
`timescale 1ns/1ps
module bps_rise_detect (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic level_in,
  output logic rise_q
);

  logic prev_q;

  // ----------------------------------------------------------------------
  // Edge capture
  // ----------------------------------------------------------------------
  // Reset loads the previous level as high so a clock already high at
  // release is not mistaken for a fresh step.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= level_in;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rise_q <= 1'b0;
    end else begin
      rise_q <= level_in & ~prev_q;
    end
  end

endmodule

// ===== verilog/bps_sequencer.sv
// Phase sequencer for a two-phase bipolar stepper motor driver.
`timescale 1ns/1ps
`include "bps_cfg.svh"

module bps_sequencer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic step_clk_in,
  input wire logic rotation_direction_select,
  input wire logic step_size_select,
  input wire logic preset_in,
  output logic coil_a_out_pos,
  output logic coil_a_out_neg,
  output logic coil_b_out_pos,
  output logic coil_b_out_neg,
  output logic coil_a_drive_en,
  output logic coil_b_drive_en
);

  // ----------------------------------------------------------------------
  // Step edge
  // ----------------------------------------------------------------------
  logic step_rise;

  bps_rise_detect u_rise (
    .clk(clk),
    .rst_n(rst_n),
    .level_in(step_clk_in),
    .rise_q(step_rise)
  );

  // ----------------------------------------------------------------------
  // Step qualification
  // ----------------------------------------------------------------------
  // A rise caught in the last cycle of a preset pulse is dropped, not held
  // over, so the home pattern always stands until a fresh step edge.
  logic preset_q;
  logic step_take;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      preset_q <= 1'b0;
    end else begin
      preset_q <= preset_in;
    end
  end

  assign step_take = step_rise & ~preset_in & ~preset_q;

  // ----------------------------------------------------------------------
  // Neighbour positions
  // ----------------------------------------------------------------------
  bps_pkg::bps_pos_t pos_q;
  bps_pkg::bps_pos_t pos_d;
  bps_pkg::bps_pos_t fwd_half;
  bps_pkg::bps_pos_t rev_half;
  bps_pkg::bps_pos_t fwd_full;
  bps_pkg::bps_pos_t rev_full;

  // A full step taken from a one-coil position moves only one place so
  // the motor lands back on a two-coil position instead of skipping it.
  always_comb begin
    unique case (pos_q)
      bps_pkg::BPS_P0: begin
        fwd_half = bps_pkg::BPS_P1;
        rev_half = bps_pkg::BPS_P7;
        fwd_full = bps_pkg::BPS_P2;
        rev_full = bps_pkg::BPS_P6;
      end
      bps_pkg::BPS_P1: begin
        fwd_half = bps_pkg::BPS_P2;
        rev_half = bps_pkg::BPS_P0;
        fwd_full = bps_pkg::BPS_P2;
        rev_full = bps_pkg::BPS_P0;
      end
      bps_pkg::BPS_P2: begin
        fwd_half = bps_pkg::BPS_P3;
        rev_half = bps_pkg::BPS_P1;
        fwd_full = bps_pkg::BPS_P4;
        rev_full = bps_pkg::BPS_P0;
      end
      bps_pkg::BPS_P3: begin
        fwd_half = bps_pkg::BPS_P4;
        rev_half = bps_pkg::BPS_P2;
        fwd_full = bps_pkg::BPS_P4;
        rev_full = bps_pkg::BPS_P2;
      end
      bps_pkg::BPS_P4: begin
        fwd_half = bps_pkg::BPS_P5;
        rev_half = bps_pkg::BPS_P3;
        fwd_full = bps_pkg::BPS_P6;
        rev_full = bps_pkg::BPS_P2;
      end
      bps_pkg::BPS_P5: begin
        fwd_half = bps_pkg::BPS_P6;
        rev_half = bps_pkg::BPS_P4;
        fwd_full = bps_pkg::BPS_P6;
        rev_full = bps_pkg::BPS_P4;
      end
      bps_pkg::BPS_P6: begin
        fwd_half = bps_pkg::BPS_P7;
        rev_half = bps_pkg::BPS_P5;
        fwd_full = bps_pkg::BPS_P0;
        rev_full = bps_pkg::BPS_P4;
      end
      bps_pkg::BPS_P7: begin
        fwd_half = bps_pkg::BPS_P0;
        rev_half = bps_pkg::BPS_P6;
        fwd_full = bps_pkg::BPS_P0;
        rev_full = bps_pkg::BPS_P6;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Position update
  // ----------------------------------------------------------------------
  bps_pkg::bps_pos_t step_pos;

  always_comb begin
    if (rotation_direction_select) begin
      if (step_size_select) begin
        step_pos = rev_half;
      end else begin
        step_pos = rev_full;
      end
    end else begin
      if (step_size_select) begin
        step_pos = fwd_half;
      end else begin
        step_pos = fwd_full;
      end
    end
  end

  always_comb begin
    pos_d = pos_q;
    if (preset_in) begin
      pos_d = bps_pkg::bps_pos_t'(`BPS_POS_HOME);
    end else if (step_take) begin
      pos_d = step_pos;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pos_q <= bps_pkg::bps_pos_t'(`BPS_POS_HOME);
    end else begin
      pos_q <= pos_d;
    end
  end

  // ----------------------------------------------------------------------
  // Coil pattern
  // ----------------------------------------------------------------------
  bps_pkg::bps_coil_t coil_d;
  bps_pkg::bps_drive_t drive_d;

  always_comb begin
    unique case (pos_d)
      bps_pkg::BPS_P0: begin
        coil_d = `BPS_PAT_P0;
        drive_d = `BPS_EN_BOTH;
      end
      bps_pkg::BPS_P1: begin
        coil_d = `BPS_PAT_P1;
        drive_d = `BPS_EN_B;
      end
      bps_pkg::BPS_P2: begin
        coil_d = `BPS_PAT_P2;
        drive_d = `BPS_EN_BOTH;
      end
      bps_pkg::BPS_P3: begin
        coil_d = `BPS_PAT_P3;
        drive_d = `BPS_EN_A;
      end
      bps_pkg::BPS_P4: begin
        coil_d = `BPS_PAT_P4;
        drive_d = `BPS_EN_BOTH;
      end
      bps_pkg::BPS_P5: begin
        coil_d = `BPS_PAT_P5;
        drive_d = `BPS_EN_B;
      end
      bps_pkg::BPS_P6: begin
        coil_d = `BPS_PAT_P6;
        drive_d = `BPS_EN_BOTH;
      end
      bps_pkg::BPS_P7: begin
        coil_d = `BPS_PAT_P7;
        drive_d = `BPS_EN_A;
      end
    endcase
    if (preset_in) begin
      coil_d = `BPS_PAT_OFF;
      drive_d = `BPS_EN_NONE;
    end
  end

  // ----------------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------------
  // Outputs are registered alongside the position so the pins never
  // glitch while the table decodes.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      coil_a_out_pos <= 1'b0;
      coil_a_out_neg <= 1'b0;
      coil_b_out_pos <= 1'b0;
      coil_b_out_neg <= 1'b0;
    end else begin
      coil_a_out_pos <= coil_d.a_pos;
      coil_a_out_neg <= coil_d.a_neg;
      coil_b_out_pos <= coil_d.b_pos;
      coil_b_out_neg <= coil_d.b_neg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      coil_a_drive_en <= 1'b0;
      coil_b_drive_en <= 1'b0;
    end else begin
      coil_a_drive_en <= drive_d.coil_a;
      coil_b_drive_en <= drive_d.coil_b;
    end
  end

endmodule

// ===== verif/bps_sequencer_sva.sv
// Checker for the stepper phase sequencer outputs.
`timescale 1ns/1ps
module bps_sequencer_sva (
  input logic clk,
  input logic rst_n,
  input logic step_clk_in,
  input logic rotation_direction_select,
  input logic step_size_select,
  input logic preset_in,
  input logic coil_a_out_pos,
  input logic coil_a_out_neg,
  input logic coil_b_out_pos,
  input logic coil_b_out_neg,
  input logic coil_a_drive_en,
  input logic coil_b_drive_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [3:0] coil;
  logic [1:0] en;
  assign coil = {coil_a_out_pos, coil_a_out_neg, coil_b_out_pos, coil_b_out_neg};
  assign en = {coil_a_drive_en, coil_b_drive_en};
  sequence rise_s;
    !step_clk_in ##1 (step_clk_in && !preset_in);
  endsequence
  // ----
  // Checks
  // ----
  chk_preset_off: assert property (preset_in |=> coil == 4'h0 && en == 2'h0)
    else $error("drivers on in preset");
  chk_home_after: assert property ($fell(preset_in) |=> coil == 4'hA && en == 2'h3)
    else $error("no home state");
  chk_step_only: assert property ($changed({coil, en}) |-> $past(preset_in) ||
    $past(preset_in, 2) || !$past(rst_n) || !$past(rst_n, 2) ||
    ($past(step_clk_in, 2) && !$past(step_clk_in, 3)))
    else $error("change without step");
  chk_full_two: assert property (rise_s ##1 (!step_size_select && !preset_in &&
    en == 2'h3) |=> en == 2'h3 && $changed(coil)) else $error("full step");
  chk_half_one: assert property (rise_s ##1 (step_size_select && !preset_in &&
    en == 2'h3) |=> en inside {2'h1, 2'h2}) else $error("half step");
  chk_dir_home: assert property (rise_s ##1 (!preset_in && coil == 4'hA) |=>
    coil == ($past(rotation_direction_select) ? ($past(step_size_select) ?
    4'h8 : 4'h9) : ($past(step_size_select) ? 4'h2 : 4'h6))) else $error("direction");
  cover property (rise_s ##1 step_size_select);
  cover property (rise_s ##1 rotation_direction_select);
  cover property ($fell(preset_in));
endmodule

// ===== verif/bps_ctl_model.sv
// Stepping controller model driving the sequencer step clock and select inputs.
`timescale 1ns/1ps
module bps_ctl_model (
  input logic clk,
  output logic step_clk_in,
  output logic rotation_direction_select,
  output logic step_size_select
);
  // Selects never float and the step clock idles low.
  initial begin
    step_clk_in = 1'b0;
    rotation_direction_select = 1'b0;
    step_size_select = 1'b0;
  end
  // Selects stay put past the sampling edge after the rise.
  task automatic step(input logic dir, input logic size, input int gap, input int hi);
    @(negedge clk);
    rotation_direction_select = dir;
    step_size_select = size;
    step_clk_in = 1'b1;
    repeat (hi) @(negedge clk);
    step_clk_in = 1'b0;
    repeat (gap) @(negedge clk);
  endtask
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the stepper phase sequencer.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic preset_in = 1'b0;
  logic step_clk_in, rotation_direction_select, step_size_select;
  wire bps_pkg::bps_coil_t coil;
  wire [1:0] en;
  int err_total = 0;
  int checks_done = 0;
  // Rows: direction, size, coil pattern, enables.
  logic [7:0] rows [12] = '{8'h49, 8'h5B, 8'h17, 8'hD2, 8'h9B, 8'hAB, 8'hE2, 8'hE7,
    8'h2B, 8'hA7, 8'hC5, 8'h27};
  always #25 clk = ~clk;
  bps_ctl_model u_ctl (.clk(clk), .step_clk_in(step_clk_in),
    .rotation_direction_select(rotation_direction_select), .step_size_select(step_size_select));
  bps_sequencer u_dut (.clk(clk), .rst_n(rst_n), .step_clk_in(step_clk_in),
    .rotation_direction_select(rotation_direction_select), .step_size_select(step_size_select),
    .preset_in(preset_in), .coil_a_out_pos(coil.a_pos), .coil_a_out_neg(coil.a_neg),
    .coil_b_out_pos(coil.b_pos), .coil_b_out_neg(coil.b_neg), .coil_a_drive_en(en[1]),
    .coil_b_drive_en(en[0]));
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----
  // Tests
  // ----
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    preset_in = 1'b1;
    u_ctl.step(1'b0, 1'b1, 3, 1);
    `CHK({coil, en}, 6'h00)
    preset_in = 1'b0;
    repeat (4) @(negedge clk);
    `CHK({coil, en}, 6'h2B)
    for (int i = 0; i < 12; i++) begin
      u_ctl.step(rows[i][7], rows[i][6], 2, 1);
      `CHK({coil, en}, rows[i][5:0])
    end
    u_ctl.step(1'b0, 1'b1, 0, 6);
    repeat (3) @(negedge clk);
    `CHK({coil, en}, 6'h22)
    u_ctl.step(1'b0, 1'b1, 0, 1);
    u_ctl.step(1'b0, 1'b1, 2, 1);
    `CHK({coil, en}, 6'h09)
    preset_in = 1'b1;
    fork
      u_ctl.step(1'b0, 1'b1, 3, 1);
      begin
        repeat (2) @(negedge clk);
        preset_in = 1'b0;
      end
    join
    `CHK({coil, en}, 6'h2B)
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    `CHK({coil, en}, 6'h00)
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    `CHK({coil, en}, 6'h2B)
    u_ctl.step(1'b1, 1'b1, 2, 1);
    `CHK({coil, en}, 6'h22)
    end_sim();
  end
  initial begin
    repeat (2000) @(posedge clk);
    err_total++;
    end_sim();
  end
endmodule
bind bps_sequencer bps_sequencer_sva u_sva (.clk(clk), .rst_n(rst_n),
  .step_clk_in(step_clk_in), .rotation_direction_select(rotation_direction_select),
  .step_size_select(step_size_select), .preset_in(preset_in),
  .coil_a_out_pos(coil_a_out_pos), .coil_a_out_neg(coil_a_out_neg),
  .coil_b_out_pos(coil_b_out_pos), .coil_b_out_neg(coil_b_out_neg),
  .coil_a_drive_en(coil_a_drive_en), .coil_b_drive_en(coil_b_drive_en));
